// ===== src/sab_jtag_pkg.sv
// Shared constants and types for the test-port service access bus bridge.
package sab_jtag_pkg;

  // Instruction register and opcodes.
  localparam int IR_W = 5;
  localparam logic [4:0] IR_SIZED = 5'h15;
  localparam logic [4:0] IR_WORD = 5'h11;
  localparam logic [4:0] IR_BLOCK = 5'h12;
  localparam logic [4:0] IR_SYNC = 5'h17;
  localparam logic [4:0] IR_CANCEL = 5'h13;
  localparam logic [4:0] IR_RESET_VAL = 5'h1F;
  localparam logic [1:0] IR_CAPT_LO = 2'h1;

  // Data register lengths per instruction.
  localparam int DR_MAX = 39;
  localparam logic [5:0] LEN_SIZED = 6'h27;
  localparam logic [5:0] LEN_WORD = 6'h23;
  localparam logic [5:0] LEN_BLOCK = 6'h22;
  localparam logic [5:0] LEN_SYNC = 6'h10;
  localparam logic [5:0] LEN_BYPASS = 6'h01;

  // Field positions inside the data register.
  localparam int POS_DIR = 0;
  localparam int POS_SIZE = 1;
  localparam int POS_SADDR = 3;
  localparam int POS_WADDR = 1;
  localparam int POS_STAT = 32;
  localparam int POS_WD_SIZED = 7;
  localparam int POS_WD_WORD = 3;
  localparam int POS_WD_BLOCK = 2;

  // Widths.
  localparam int ADDR_W = 36;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // Access size codes.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

endpackage : sab_jtag_pkg

// ===== src/pin_sync.sv
// Two-flop synchroniser for a group of pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Pins and synchronised levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t r;
  sync_st_t r_nxt;

  if (W < 1) begin : g_bad_w
    $error("pin_sync needs W of at least one.");
  end

  // Only the second stage is visible; the first stage is read by nothing else.
  always_comb begin
    r_nxt = r;
    r_nxt.meta = pin_in;
    r_nxt.stable = r.meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign pin_out = r.stable;
endmodule : pin_sync
`default_nettype wire

// ===== src/tap_fsm.sv
// Test-port state machine stepped on each detected test-clock rise.
`timescale 1ns/1ps
`default_nettype none
module tap_fsm
  import sab_jtag_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Step and mode select
  input wire logic step,
  input wire logic tms,
  // Current state
  output tap_state_t state
);
  typedef struct packed {
    tap_state_t st;
  } tap_st_t;

  tap_st_t r;
  tap_st_t r_nxt;

  always_comb begin
    r_nxt = r;
    if (step) begin
      unique case (r.st)
        TAP_RESET: r_nxt.st = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: r_nxt.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: r_nxt.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: r_nxt.st = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: r_nxt.st = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: r_nxt.st = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: r_nxt.st = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: r_nxt.st = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: r_nxt.st = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: r_nxt.st = tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: r_nxt.st = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: r_nxt.st = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: r_nxt.st = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: r_nxt.st = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: r_nxt.st = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: r_nxt.st = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r.st <= TAP_RESET;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign state = r.st;
endmodule : tap_fsm
`default_nettype wire

// ===== src/jtag_sab_access.sv
// Test-port bridge giving sized, word and block access to the service access bus.
//
`timescale 1ns/1ps
`default_nettype none
module jtag_sab_access
  import sab_jtag_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Test-port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // Service access bus master
  output logic sab_req,
  output logic sab_we,
  output logic [ADDR_W-1:0] sab_addr,
  output logic [1:0] sab_size,
  output logic [DATA_W-1:0] sab_wdata,
  output logic sab_abort,
  input wire logic [DATA_W-1:0] sab_rdata,
  input wire logic sab_ack,
  input wire logic sab_err
);
  typedef struct packed {
    logic tck_d;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] ir;
    logic [DR_MAX-1:0] dr;
    logic data_ph;
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic req;
    logic we;
    logic [DATA_W-1:0] wdata;
    logic abort;
    logic err;
    logic [CNT_W-1:0] cnt;
    logic tdo;
    logic tdo_oe_n;
  } bridge_st_t;

  bridge_st_t r;
  bridge_st_t r_nxt;
  logic [2:0] pins_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rise;
  tap_state_t tap;

  // All three pins pass the same two flops, so their relative timing is kept.
  pin_sync #(.W(3)) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_in({tck, tms, tdi}),
    .pin_out(pins_s)
  );

  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  assign rise = tck_s & ~r.tck_d;

  tap_fsm u_tap (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .step(rise),
    .tms(tms_s),
    .state(tap)
  );

  function automatic logic [5:0] dr_len(input logic [IR_W-1:0] code);
    unique case (code)
      IR_SIZED: dr_len = LEN_SIZED;
      IR_WORD: dr_len = LEN_WORD;
      IR_BLOCK: dr_len = LEN_BLOCK;
      IR_SYNC: dr_len = LEN_SYNC;
      default: dr_len = LEN_BYPASS;
    endcase
  endfunction : dr_len

  always_comb begin
    logic busy;
    logic fall;
    logic [5:0] len;
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] next_addr;
    busy = 1'b0;
    fall = 1'b0;
    len = '0;
    inc = '0;
    next_addr = '0;
    r_nxt = r;
    fall = ~tck_s & r.tck_d;
    r_nxt.tck_d = tck_s;
    busy = r.req | (r.cnt != '0);
    len = dr_len(r.ir);
    inc = ADDR_W'(36'h1 << r.size);
    next_addr = ADDR_W'(r.addr + inc);

    if (r.cnt != '0) begin
      r_nxt.cnt = CNT_W'(r.cnt - 16'h1);
    end

    // A transfer under abort ends as a timeout even if the slave acknowledges.
    if (r.req && (sab_ack || sab_err)) begin
      r_nxt.req = 1'b0;
      r_nxt.abort = 1'b0;
      if (r.abort || sab_err) begin
        r_nxt.err = 1'b1;
      end else if (!r.we) begin
        r_nxt.rdata = sab_rdata;
      end
    end

    // Output changes on the falling test-clock edge, as the master samples on the rise.
    if (fall) begin
      r_nxt.tdo = (tap == TAP_SHIFT_IR) ? r.ir_sr[0] : r.dr[0];
      r_nxt.tdo_oe_n = !((tap == TAP_SHIFT_IR) || (tap == TAP_SHIFT_DR));
    end

    if (rise) begin
      if (tap == TAP_RESET) begin
        r_nxt.ir = IR_RESET_VAL;
        r_nxt.data_ph = 1'b0;
      end else if (tap == TAP_CAP_IR) begin
        r_nxt.ir_sr = {1'b0, r.err, busy, IR_CAPT_LO};
      end else if (tap == TAP_SHIFT_IR) begin
        r_nxt.ir_sr = {tdi_s, r.ir_sr[IR_W-1:1]};
      end else if (tap == TAP_UPD_IR) begin
        r_nxt.ir = r.ir_sr;
        r_nxt.data_ph = 1'b0;
        // A transfer that ends in this very cycle wins, so no abort is left behind it.
        if (r.ir_sr == IR_CANCEL && r.req && !(sab_ack || sab_err)) begin
          r_nxt.abort = 1'b1;
        end
        // Entering block read mode prefetches the next location at once.
        if (r.ir_sr == IR_BLOCK && r.rd && !busy && r.size != SZ_BAD) begin
          r_nxt.addr = next_addr;
          r_nxt.req = 1'b1;
          r_nxt.we = 1'b0;
          r_nxt.err = 1'b0;
        end
      end else if (tap == TAP_CAP_DR) begin
        r_nxt.dr = '0;
        if (r.ir == IR_SYNC) begin
          r_nxt.dr[1:0] = {r.err, busy};
        end else if (r.ir == IR_SIZED || r.ir == IR_WORD || r.ir == IR_BLOCK) begin
          if ((r.data_ph || r.ir == IR_BLOCK) && r.rd) begin
            r_nxt.dr[POS_STAT+1:0] = {r.err, busy, r.rdata};
          end else begin
            r_nxt.dr[1:0] = {r.err, busy};
          end
        end
      end else if (tap == TAP_SHIFT_DR) begin
        r_nxt.dr = {1'b0, r.dr[DR_MAX-1:1]};
        r_nxt.dr[len - 6'h1] = tdi_s;
      end else if (tap == TAP_UPD_DR && !busy) begin
        if (r.ir == IR_SIZED) begin
          r_nxt.data_ph = ~r.data_ph;
          if (!r.data_ph) begin
            r_nxt.rd = r.dr[POS_DIR];
            r_nxt.size = r.dr[POS_SIZE+:2];
            r_nxt.addr = r.dr[POS_SADDR+:ADDR_W];
            r_nxt.err = (r.dr[POS_SIZE+:2] == SZ_BAD);
            if (r.dr[POS_DIR] && r.dr[POS_SIZE+:2] != SZ_BAD) begin
              r_nxt.req = 1'b1;
              r_nxt.we = 1'b0;
            end
          end else if (!r.rd && r.size != SZ_BAD) begin
            r_nxt.req = 1'b1;
            r_nxt.we = 1'b1;
            r_nxt.wdata = r.dr[POS_WD_SIZED+:DATA_W];
            r_nxt.err = 1'b0;
          end
        end else if (r.ir == IR_WORD) begin
          r_nxt.data_ph = ~r.data_ph;
          if (!r.data_ph) begin
            r_nxt.rd = r.dr[POS_DIR];
            r_nxt.size = SZ_WORD;
            r_nxt.addr = {r.dr[POS_WADDR+:ADDR_W-2], 2'h0};
            r_nxt.err = 1'b0;
            if (r.dr[POS_DIR]) begin
              r_nxt.req = 1'b1;
              r_nxt.we = 1'b0;
            end
          end else if (!r.rd) begin
            r_nxt.req = 1'b1;
            r_nxt.we = 1'b1;
            r_nxt.wdata = r.dr[POS_WD_WORD+:DATA_W];
            r_nxt.err = 1'b0;
          end
        end else if (r.ir == IR_BLOCK && r.size != SZ_BAD) begin
          r_nxt.addr = next_addr;
          r_nxt.req = 1'b1;
          r_nxt.we = ~r.rd;
          r_nxt.wdata = r.dr[POS_WD_BLOCK+:DATA_W];
          r_nxt.err = 1'b0;
        end else if (r.ir == IR_SYNC) begin
          // A poll scan also passes Update-DR, so only the phase after a poll reloads.
          r_nxt.data_ph = ~r.data_ph;
          if (!r.data_ph) begin
            r_nxt.cnt = r.dr[CNT_W-1:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.ir <= IR_RESET_VAL;
      r.tdo_oe_n <= 1'b1;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  assign tdo = r.tdo;
  assign tdo_oe_n = r.tdo_oe_n;
  assign sab_req = r.req;
  assign sab_we = r.we;
  assign sab_addr = r.addr;
  assign sab_size = r.size;
  assign sab_wdata = r.wdata;
  assign sab_abort = r.abort;
endmodule : jtag_sab_access
`default_nettype wire

// ===== test/jtag_sab_access_props.sv
// Bus-side checker for the test-port bridge.
`timescale 1ns/1ps
`default_nettype none
module jtag_sab_access_props
  import sab_jtag_pkg::*;
(
  // Clock
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic sab_req,
  input wire logic sab_we,
  input wire logic [ADDR_W-1:0] sab_addr,
  input wire logic [1:0] sab_size,
  input wire logic [DATA_W-1:0] sab_wdata,
  input wire logic sab_abort,
  input wire logic sab_ack,
  input wire logic sab_err
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_wait;
    sab_req && !sab_ack && !sab_err;
  endsequence
  sequence s_end;
    sab_req && (sab_ack || sab_err);
  endsequence
  AST_REQ_HOLD: assert property (s_wait |=> sab_req) else $error("req dropped");
  AST_REQ_END: assert property (s_end |=> !sab_req) else $error("req stuck");
  AST_FIELD_HOLD: assert property (
    s_wait |=> $stable({sab_we, sab_addr, sab_size, sab_wdata})) else $error("fields moved");
  AST_SIZE_OK: assert property (sab_req |-> sab_size != SZ_BAD) else $error("bad size");
  AST_ABORT_REQ: assert property (sab_abort |-> sab_req) else $error("stray abort");
  AST_ABORT_HOLD: assert property (
    s_wait and sab_abort |=> sab_abort) else $error("abort dropped");
  AST_ABORT_CLR: assert property (
    s_end and sab_abort |=> !sab_abort [*2]) else $error("abort stuck");
  // The past-reset guard keeps a reset in mid-transfer from looking like a lost answer.
  AST_END_CAUSE: assert property (
    !$past(srst) && $fell(sab_req) |-> $past(sab_ack || sab_err)) else $error("req fell");
endmodule : jtag_sab_access_props
bind jtag_sab_access jtag_sab_access_props i_props (.clk, .srst, .sab_req, .sab_we,
  .sab_addr, .sab_size, .sab_wdata, .sab_abort, .sab_ack, .sab_err);
`default_nettype wire

// ===== test/sab_slave_model.sv
// Bus slave model that answers after a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module sab_slave_model (
  // Clock
  input wire logic clk,
  input wire logic srst,
  // Bus
  input wire logic sab_req,
  input wire logic [35:0] sab_addr,
  input wire logic [7:0] dly,
  output logic sab_ack,
  output logic [31:0] sab_rdata
);
  logic [7:0] wait_r;
  // Data flips outside the answer cycle so a late sample never passes for data.
  always_ff @(posedge clk) begin
    sab_ack <= 1'b0;
    sab_rdata <= ~sab_rdata;
    if (srst || !sab_req || sab_ack) begin
      wait_r <= 8'h0;
    end else if (wait_r == dly) begin
      sab_ack <= 1'b1;
      sab_rdata <= {sab_addr[31:2], 2'h0} ^ 32'hA5A5_0000;
    end else begin
      wait_r <= wait_r + 8'h1;
    end
  end
endmodule : sab_slave_model
`default_nettype wire

// ===== test/test_jtag_sab_access.sv
// Self-checking bench for the test-port bus bridge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module test_jtag_sab_access
  import sab_jtag_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  logic tdo, tdo_oe_n, sab_req, sab_we, sab_abort, sab_ack;
  logic [35:0] sab_addr;
  logic [1:0] sab_size;
  logic [31:0] sab_wdata, sab_rdata;
  logic [7:0] dly = 8'h28;
  int checks = 0;
  int miscompares = 0;
  always #50 clk = ~clk;
  jtag_sab_access i_dut (.clk, .srst, .ce(1'b1), .tck, .tms, .tdi, .tdo, .tdo_oe_n,
    .sab_req, .sab_we, .sab_addr, .sab_size, .sab_wdata, .sab_abort, .sab_rdata,
    .sab_ack, .sab_err(1'b0));
  sab_slave_model i_slv (.clk, .srst, .sab_req, .sab_addr, .dly, .sab_ack, .sab_rdata);
  function automatic logic [31:0] rd(input logic [35:0] a);
    return {a[31:2], 2'h0} ^ 32'hA5A5_0000;
  endfunction : rd
  // One test-clock period of eight system clocks; tdo is taken just before the rise.
  task automatic tk(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (4) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : tk
  task automatic scan(input logic ir, input int n, input logic [38:0] di,
      output logic [38:0] dq);
    logic q;
    dq = '0;
    tk(1'b1, 1'b0, q);
    if (ir) tk(1'b1, 1'b0, q);
    tk(1'b0, 1'b0, q);
    tk(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, di[i], q);
      dq[i] = q;
      if (i == 0) `CHK("oe", 1'b0, tdo_oe_n)
    end
    tk(1'b1, 1'b0, q);
    tk(1'b0, 1'b0, q);
    `CHK("oe off", 1'b1, tdo_oe_n)
  endtask : scan
  task automatic ir(input logic [4:0] c, output logic [38:0] q);
    scan(1'b1, 5, {34'h0, c}, q);
  endtask : ir
  task automatic wreq(input logic w, input logic [35:0] a, input logic [1:0] s,
      input logic [31:0] d);
    `CHK("req", 1'b1, sab_req)
    `CHK("we", w, sab_we)
    `CHK("addr", a, sab_addr)
    `CHK("size", s, sab_size)
    if (w) `CHK("wdata", d, sab_wdata)
    for (int k = 0; k < 400 && sab_req; k++) @(posedge clk);
    `CHK("req end", 1'b0, sab_req)
  endtask : wreq
  task automatic t_sized();
    logic [38:0] q;
    ir(IR_SIZED, q);
    `CHK("ir", 5'h01, q[4:0])
    scan(1'b0, 39, {36'h9_1234_5679, SZ_HALF, 1'b0}, q);
    `CHK("addr phase", 1'b0, sab_req)
    scan(1'b0, 39, {32'hCAFE_F00D, 7'h0}, q);
    wreq(1'b1, 36'h9_1234_5679, SZ_HALF, 32'hCAFE_F00D);
    scan(1'b0, 39, {36'h108, SZ_BYTE, 1'b1}, q);
    wreq(1'b0, 36'h108, SZ_BYTE, 32'h0);
    scan(1'b0, 39, 39'h0, q);
    `CHK("rdata", rd(36'h108), q[31:0])
    scan(1'b0, 39, {36'h0, SZ_BAD, 1'b1}, q);
    `CHK("bad", 1'b0, sab_req)
    ir(IR_SIZED, q);
    `CHK("err", 5'h09, q[4:0])
  endtask : t_sized
  task automatic t_word();
    logic [38:0] q;
    ir(IR_WORD, q);
    scan(1'b0, 35, {4'h0, 34'h2_0000_0041, 1'b1}, q);
    wreq(1'b0, 36'h8_0000_0104, SZ_WORD, 32'h0);
    scan(1'b0, 35, 39'h0, q);
    `CHK("word", rd(36'h8_0000_0104), q[31:0])
  endtask : t_word
  task automatic t_block();
    logic [38:0] q;
    for (int s = 0; s < 3; s++) begin
      ir(IR_SIZED, q);
      scan(1'b0, 39, {36'h200, s[1:0], 1'b1}, q);
      wreq(1'b0, 36'h200, s[1:0], 32'h0);
      ir(IR_BLOCK, q);
      wreq(1'b0, 36'h200 + (36'h1 << s), s[1:0], 32'h0);
    end
    scan(1'b0, 8, 39'h0, q);
    `CHK("short", rd(36'h204) & 32'hFF, q[31:0])
    wreq(1'b0, 36'h208, SZ_WORD, 32'h0);
  endtask : t_block
  task automatic t_sync();
    logic [38:0] q;
    ir(IR_SYNC, q);
    scan(1'b0, 16, 39'h100, q);
    scan(1'b0, 16, 39'h0, q);
    `CHK("busy", 1'b1, q[0])
    for (int k = 0; k < 20 && q[0] !== 1'b0; k++) scan(1'b0, 2, 39'h0, q);
    `CHK("idle", 1'b0, q[0])
  endtask : t_sync
  task automatic t_cancel();
    logic [38:0] q;
    dly <= 8'hFF;
    ir(IR_SIZED, q);
    scan(1'b0, 39, {36'h300, SZ_WORD, 1'b1}, q);
    `CHK("slow", 1'b1, sab_req)
    ir(IR_CANCEL, q);
    `CHK("abort", 1'b1, sab_abort)
    for (int k = 0; k < 400 && sab_req; k++) @(posedge clk);
    `CHK("cancel end", 1'b0, sab_req)
    dly <= 8'h28;
    ir(IR_SIZED, q);
    `CHK("timeout", 5'h09, q[4:0])
    scan(1'b0, 39, {36'h300, SZ_WORD, 1'b1}, q);
    wreq(1'b0, 36'h300, SZ_WORD, 32'h0);
  endtask : t_cancel
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    logic b;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tk(1'b0, 1'b0, b);
    t_sized();
    t_word();
    t_block();
    t_sync();
    t_cancel();
    stop_test();
  end
  initial begin
    #8000000;
    miscompares++;
    stop_test();
  end
endmodule : test_jtag_sab_access
`default_nettype wire
